/* File: selftest_cfg.svh */
// Offsets, field positions, reset values and codes for the self-test block.
// Assumes a 12-bit byte address on the register bus.
`ifndef SELFTEST_CFG_SVH
`define SELFTEST_CFG_SVH
`define OFS_START     12'h380
`define OFS_EXT_CTL   12'h388
`define OFS_DLY_SYM   12'h38C
`define OFS_STATUS    12'h394
`define CTL_MASK      32'h1FFFFFFF
`define CTL_RESET     32'h0400007F
`define DLY_RESET     9'h1BC
`define BIT_FORCED    28
`define LANE_HI       27
`define LANE_LO       26
`define BIT_NO_HALT   25
`define BIT_LOOP_FOREVER 24
`define BIT_LOOP_FOREVER_ALIAS `BIT_LOOP_FOREVER
`define SKIP_HI       23
`define SKIP_LO       12
`define LIMIT_HI      11
`define LIMIT_LO      0
`define LANE_NONE     2'h0
`define LANE_MOD4     2'h1
`define LANE_MOD8     2'h2
`define SYM_COM       9'h1BC
`define SYM_SKP       9'h11C
`define SYM_IDL       9'h17C
`define FIFO_DEPTH    16
`define TX_W          10
`endif

/* File: selftest_pkg.sv */
// Types shared by the self-test engine.
// Assumes nothing beyond the config header.
package selftest_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TRAIN, ST_DATA, ST_SKIP, ST_EIOS, ST_DONE
  } eng_state_e;
  typedef struct packed {
    logic [31:0] ctl;
    logic [8:0]  dly;
    logic        port_start;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    eng_state_e  st;
    logic [2:0]  sym;
    logic [11:0] sets;
    logic [11:0] skp;
    logic        dset;
    logic        frc;
    logic        err_seen;
    logic        halted;
    logic        done;
    logic [7:0]  err_cap;
    logic        train_req;
    logic        override;
    logic        discard;
    logic        running;
  } eng_s;
endpackage

/* File: selftest_engine.sv */
// Link self-test pattern engine with APB registers and a transmit FIFO.
// Assumes pattern, error and training inputs come from logic on pclk.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_cfg.svh"

module selftest_fifo #(
  parameter int WIDTH = `TX_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  // Shift style keeps the head word in a flip-flop at entry zero
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               cnt;
    logic                        ovalid;
    logic                        iready;
  } fifo_s;

  fifo_s r_ff;
  fifo_s nxt_r;
  logic  pop;
  logic  push;
  logic [CW-1:0] wpos;
  logic [DEPTH-1:0][WIDTH-1:0] shifted;

  // Each entry takes its upper neighbour on a pop; the top entry holds
  for (genvar g = 0; g < DEPTH; g++) begin : g_shift
    if (g < DEPTH - 1) begin : g_mid
      assign shifted[g] = r_ff.mem[g+1];
    end else begin : g_top
      assign shifted[g] = r_ff.mem[g];
    end
  end

  always_comb begin
    nxt_r = r_ff;
    pop   = r_ff.ovalid & out_ready;
    push  = in_valid & r_ff.iready;
    wpos  = r_ff.cnt;
    if (pop) begin
      nxt_r.mem = shifted;
      wpos      = r_ff.cnt - CW'(1);
    end
    if (push) begin
      nxt_r.mem[wpos] = in_data;
    end
    nxt_r.cnt    = r_ff.cnt + CW'(push) - CW'(pop);
    // Flags come from the next count, so they stay registered
    nxt_r.ovalid = (nxt_r.cnt != '0);
    nxt_r.iready = (nxt_r.cnt != CW'(DEPTH));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff        <= '0;
      r_ff.iready <= 1'b1;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign in_ready  = r_ff.iready;
  assign out_valid = r_ff.ovalid;
  assign out_data  = r_ff.mem[0];
endmodule

module selftest_engine
  import selftest_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output var  logic [31:0]     prdata,
  output var  logic            pready,
  output var  logic            pslverr,
  input  wire logic            global_test_start,
  input  wire logic [31:0]     pattern_sym,
  input  wire logic [3:0]      pattern_kflag,
  input  wire logic            train_ack,
  input  wire logic            err_in,
  input  wire logic [7:0]      err_code,
  output var  logic [`TX_W-1:0] tx_data,
  output var  logic            tx_valid,
  input  wire logic            tx_ready,
  output var  logic [1:0]      lane_group_select,
  output var  logic            train_req,
  output var  logic            tx_override,
  output var  logic            rx_discard,
  output var  logic            test_running,
  output var  logic            test_done
);
  eng_s r_ff;
  eng_s nxt_r;

  logic             push;
  logic [`TX_W-1:0] push_data;
  logic             fifo_ready;
  logic             setup;
  logic             acc;
  logic             hit;
  logic [31:0]      rdval;
  logic             start;
  logic             forced_entry;
  logic [1:0]       lane_grp;
  logic             no_halt_on_error;
  logic             loop_forever;
  logic [11:0]      skip_interval;
  logic [11:0]      loop_limit;
  logic [7:0]       pat;
  logic             pat_k;
  logic             active;
  logic [31:0]      status;
  logic [8:0]       slot_sym [4];

  // One word per pattern slot, K flag above the byte
  for (genvar g = 0; g < 4; g++) begin : g_slot
    assign slot_sym[g] = {pattern_kflag[g], pattern_sym[8*g +: 8]};
  end

  // Ordered sets open with a comma, then repeat their fill symbol
  function automatic logic [`TX_W-1:0] os_word(input logic [2:0] idx,
                                                input logic [8:0] fill);
    logic [8:0] s;
    s = (idx == 3'h0) ? `SYM_COM : fill;
    return {1'b0, s};
  endfunction

  // Status fields pack into one read-only word
  always_comb begin
    status        = '0;
    status[0]     = r_ff.running;
    status[1]     = r_ff.done;
    status[2]     = r_ff.halted;
    status[3]     = r_ff.err_seen;
    status[15:8]  = r_ff.err_cap;
    status[27:16] = r_ff.sets;
  end

  always_comb begin
    nxt_r            = r_ff;
    push             = 1'b0;
    push_data        = '0;
    rdval            = '0;
    hit              = 1'b1;
    forced_entry     = r_ff.ctl[`BIT_FORCED];
    lane_grp         = r_ff.ctl[`LANE_HI:`LANE_LO];
    no_halt_on_error = r_ff.ctl[`BIT_NO_HALT];
    loop_forever     = r_ff.ctl[`BIT_LOOP_FOREVER];
    skip_interval    = r_ff.ctl[`SKIP_HI:`SKIP_LO];
    loop_limit       = r_ff.ctl[`LIMIT_HI:`LIMIT_LO];
    start = r_ff.port_start | global_test_start;
    pat   = slot_sym[r_ff.sym[1:0]][7:0];
    pat_k = slot_sym[r_ff.sym[1:0]][8];
    active = (r_ff.st == ST_DATA) || (r_ff.st == ST_SKIP) ||
             (r_ff.st == ST_EIOS);

    // Register bus: zero-wait answer, registered from the setup cycle
    setup = psel & ~penable;
    acc   = psel & penable & r_ff.pready;
    case (paddr)
      `OFS_START:   rdval = {31'h0, r_ff.port_start};
      `OFS_EXT_CTL: rdval = r_ff.ctl;
      `OFS_DLY_SYM: rdval = {23'h0, r_ff.dly};
      `OFS_STATUS:  rdval = status;
      default: hit = 1'b0;
    endcase
    // Answer is registered so pready comes straight from a flip-flop
    nxt_r.pready  = setup;
    nxt_r.pslverr = setup & ~hit;
    nxt_r.prdata  = (setup && !pwrite) ? rdval : 32'h0;
    if (acc && pwrite) begin
      case (paddr)
        `OFS_START:   nxt_r.port_start = pwdata[0];
        `OFS_EXT_CTL: nxt_r.ctl = pwdata & `CTL_MASK;
        `OFS_DLY_SYM: nxt_r.dly = pwdata[8:0];
        default: ;
      endcase
    end

    // Pattern engine; a full FIFO stalls it symbol by symbol
    case (r_ff.st)
      ST_IDLE: begin
        if (start) begin
          nxt_r.sets     = '0;
          nxt_r.skp      = '0;
          nxt_r.sym      = '0;
          nxt_r.dset     = 1'b0;
          nxt_r.err_seen = 1'b0;
          nxt_r.halted   = 1'b0;
          nxt_r.done     = 1'b0;
          nxt_r.err_cap  = '0;
          // Mode is latched so later writes cannot flip it mid-run
          nxt_r.frc      = forced_entry;
          if (!loop_forever && loop_limit == 12'h000) begin
            nxt_r.st = ST_EIOS;
          end else if (forced_entry) begin
            nxt_r.st = ST_DATA;
          end else begin
            nxt_r.st = ST_TRAIN;
          end
        end
      end

      ST_TRAIN: begin
        // A start that drops while training abandons the run
        if (!start) begin
          nxt_r.st = ST_IDLE;
        end else if (train_ack) begin
          nxt_r.st = ST_DATA;
        end
      end

      ST_DATA: begin
        if (fifo_ready) begin
          push = 1'b1;
          if (r_ff.dset) begin
            push_data = {1'b1, r_ff.dly};
          end else begin
            push_data = {1'b0, pat_k, pat};
          end
          nxt_r.sym = r_ff.sym + 3'h1;
          if (r_ff.sym == 3'h7) begin
            nxt_r.sets = r_ff.sets + 12'h001;
            nxt_r.skp  = r_ff.skp + 12'h001;
            case (lane_grp)
              `LANE_MOD4: nxt_r.dset = (nxt_r.sets[1:0] == 2'h3);
              `LANE_MOD8: nxt_r.dset = (nxt_r.sets[2:0] == 3'h7);
              `LANE_NONE: nxt_r.dset = 1'b0;
              // Reserved 11 sends no delay sets, like 00
              default:    nxt_r.dset = 1'b0;
            endcase
            // A dropped start ends the run only at a set boundary
            if ((!loop_forever && nxt_r.sets == loop_limit) ||
                !start) begin
              nxt_r.st = ST_EIOS;
            end else if (skip_interval != 12'h000 &&
                         nxt_r.skp == skip_interval) begin
              nxt_r.st  = ST_SKIP;
              nxt_r.skp = '0;
            end
          end
        end
      end

      // Skip sets do not count toward the loop limit
      ST_SKIP: begin
        if (fifo_ready) begin
          push      = 1'b1;
          push_data = os_word(r_ff.sym, `SYM_SKP);
          nxt_r.sym = r_ff.sym + 3'h1;
          if (r_ff.sym == 3'h3) begin
            nxt_r.sym = '0;
            nxt_r.st  = ST_DATA;
          end
        end
      end

      ST_EIOS: begin
        if (fifo_ready) begin
          push      = 1'b1;
          push_data = os_word(r_ff.sym, `SYM_IDL);
          nxt_r.sym = r_ff.sym + 3'h1;
          if (r_ff.sym == 3'h3) begin
            nxt_r.sym  = '0;
            nxt_r.st   = ST_DONE;
            nxt_r.done = 1'b1;
          end
        end
      end

      ST_DONE: begin
        // Start must drop before a new run; a held start never reloops
        if (!start) begin
          nxt_r.st = ST_IDLE;
        end
      end

      default: nxt_r.st = ST_IDLE;
    endcase

    // Errors are ignored while forced entry drives the link
    if (err_in && active && !r_ff.frc) begin
      nxt_r.err_seen = 1'b1;
      if (!r_ff.err_seen || no_halt_on_error) begin
        nxt_r.err_cap = err_code;
      end
      if (!no_halt_on_error && r_ff.st != ST_EIOS) begin
        nxt_r.halted = 1'b1;
        nxt_r.st     = ST_EIOS;
        nxt_r.sym    = '0;
      end
    end

    nxt_r.running   = (nxt_r.st != ST_IDLE) && (nxt_r.st != ST_DONE);
    nxt_r.train_req = (nxt_r.st == ST_TRAIN) && !nxt_r.frc;
    nxt_r.override  = nxt_r.running && nxt_r.frc;
    nxt_r.discard   = nxt_r.running && nxt_r.frc;
  end

  // Clock enable low freezes the whole state, bus answer included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff     <= '0;
      r_ff.ctl <= `CTL_RESET;
      r_ff.dly <= `DLY_RESET;
      r_ff.st  <= ST_IDLE;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  // Sixteen entries let the engine run ahead of a slow sink
  selftest_fifo #(
    .WIDTH (`TX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (fifo_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  assign prdata            = r_ff.prdata;
  assign pready            = r_ff.pready;
  assign pslverr           = r_ff.pslverr;
  assign lane_group_select = r_ff.ctl[`LANE_HI:`LANE_LO];
  assign train_req         = r_ff.train_req;
  assign tx_override       = r_ff.override;
  assign rx_discard        = r_ff.discard;
  assign test_running      = r_ff.running;
  assign test_done         = r_ff.done;
endmodule
`default_nettype wire

/* File: selftest_engine_assertions.sv */
// Checker watching the ports of the self-test engine.
// Assumes it is bound to every selftest_engine instance.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_cfg.svh"
module selftest_engine_chk (
  input wire logic        pclk, presetn, ce, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready, pslverr, tx_valid, tx_ready,
  input wire logic [9:0]  tx_data,
  input wire logic [1:0]  lane_group_select,
  input wire logic        train_req, tx_override, rx_discard,
  input wire logic        test_running, test_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  logic rd_ok;
  assign setup = psel && !penable && ce;
  assign rd_ok = pready && !pwrite && !pslverr;
  chk_no_train: assert property (tx_override |-> !train_req)
    else $error("training request during forced run");
  chk_unmapped_err: assert property (setup && !(paddr inside {`OFS_START,
    `OFS_EXT_CTL, `OFS_DLY_SYM, `OFS_STATUS}) |=>
    pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_ctl_resv: assert property (rd_ok && paddr == `OFS_EXT_CTL |->
    prdata[31:29] == 3'h0) else $error("control reserved bits set");
  chk_lane_out: assert property (rd_ok && paddr == `OFS_EXT_CTL |->
    lane_group_select == prdata[27:26]) else $error("lane group mismatch");
  chk_dly_width: assert property (rd_ok && paddr == `OFS_DLY_SYM |->
    prdata[31:9] == 23'h0) else $error("delay code wider than nine bits");
  chk_rx_discard: assert property (rx_discard == tx_override)
    else $error("receiver discard differs from override");
  chk_done_stop: assert property (test_done |-> !test_running)
    else $error("done while still running");
  chk_tx_hold: assert property (tx_valid && !tx_ready && ce |=>
    tx_valid && $stable(tx_data)) else $error("symbol dropped in stall");
  cover property ($rose(tx_override));
  cover property ($rose(train_req));
  cover property ($rose(test_done));
endmodule
bind selftest_engine selftest_engine_chk selftest_engine_chk_inst (.*);
`default_nettype wire

/* File: selftest_link_partner.sv */
// Link partner model: sink of the transmit stream, answers training.
// Assumes the pclk domain; slow, hold and rnd come from the bench.
`timescale 1ns/1ps
`default_nettype none
module selftest_link_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic train_req,
  input  wire logic slow,
  input  wire logic hold,
  input  wire logic rnd,
  output var  logic tx_ready,
  output var  logic train_ack
);
  logic [2:0] wait_ff;
  // Answer late on purpose, so the engine must really wait for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff   <= 3'h0;
      train_ack <= 1'b0;
      tx_ready  <= 1'b0;
    end else begin
      wait_ff   <= train_req ? wait_ff + 3'(wait_ff != 3'h5) : 3'h0;
      train_ack <= train_req && wait_ff == 3'h5;
      tx_ready  <= !hold && (!slow || rnd);
    end
  end
endmodule
`default_nettype wire

/* File: selftest_engine_tb_top.sv */
// Testbench for the self-test engine, its registers and stream.
// Assumes the checker is bound and the partner model sinks the stream.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_cfg.svh"
module selftest_engine_tb_top
  import selftest_pkg::*;
;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0;
  logic        pwrite = 0, global_test_start = 0, err_in = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, pattern_sym = 0, prdata, r;
  logic [3:0]  pattern_kflag = 0;
  logic [7:0]  err_code = 0;
  logic [9:0]  tx_data, q[$];
  logic [1:0]  lane_group_select;
  logic        train_ack, tx_valid, tx_ready, pready, pslverr, train_req;
  logic        tx_override, rx_discard, test_running, test_done;
  logic        slow = 0, hold = 0, rnd = 0, chk_en = 1;
  int          failures = 0, checks = 0, seed = 71;
  selftest_engine selftest_engine_inst (.*);
  selftest_link_partner selftest_link_partner_inst (.*);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) rnd <= 1'($random(seed));
  task cmp(input string n, input logic [31:0] x, input logic [31:0] s);
    checks++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  // Result notes are taken in order as each symbol leaves the stream
  always @(posedge pclk) begin
    if (presetn && tx_valid && tx_ready && chk_en) begin
      if (q.size() == 0) cmp("tx_extra", 0, 1);
      else cmp("tx_data", 32'(q.pop_front()), 32'(tx_data));
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(0, a, 0);
    cmp("prdata", x, r & m);
  endtask
  task pick;
    @(posedge pclk);
    pattern_sym <= $random(seed);
    pattern_kflag <= 4'($random(seed));
    @(posedge pclk);
  endtask
  task dset(input int n);
    for (int i = 0; i < n * 8; i++)
      q.push_back({1'b0, pattern_kflag[i%4], pattern_sym[8*(i%4)+:8]});
  endtask
  task oset(input logic [8:0] s);
    q.push_back({1'b0, `SYM_COM});
    repeat (3) q.push_back({1'b0, s});
  endtask
  task wdone;
    for (int i = 0; i < 3000 && test_done !== 1'b1; i++) @(posedge pclk);
    cmp("test_done", 1, 32'(test_done));
  endtask
  task err(input logic [7:0] c);
    err_code <= c;
    err_in <= 1;
    @(posedge pclk);
    err_in <= 0;
    @(posedge pclk);
  endtask
  task run(input logic [31:0] c, input logic g);
    apb(1, `OFS_EXT_CTL, c);
    if (g) global_test_start <= 1;
    else apb(1, `OFS_START, 1);
    if (c[`BIT_FORCED]) begin
      repeat (4) @(posedge pclk);
      cmp("tx_override", 1, 32'(tx_override));
      cmp("rx_discard", 1, 32'(rx_discard));
      cmp("train_req", 0, 32'(train_req));
      err(8'h77);
    end
    wdone();
    for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge pclk);
    cmp("tx_left", 0, 32'(q.size()));
    global_test_start <= 0;
    apb(1, `OFS_START, 0);
  endtask
  task conclude;
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(`OFS_EXT_CTL, '1, `CTL_RESET);
    rd(`OFS_DLY_SYM, '1, 32'h1BC);
    apb(1, `OFS_EXT_CTL, '1);
    rd(`OFS_EXT_CTL, '1, `CTL_MASK);
    apb(1, `OFS_DLY_SYM, 32'hFFFFFF7C);
    rd(`OFS_DLY_SYM, '1, 32'h17C);
    apb(0, 12'h3A0, 0);
    cmp("pslverr", 1, 32'(e));
    slow <= 1;
    pick();
    dset(3);
    oset(`SYM_IDL);
    run(32'h10000003, 0);
    rd(`OFS_STATUS, 32'h8, 0);
    pick();
    oset(`SYM_IDL);
    run(32'h04000000, 1);
    pick();
    dset(2);
    oset(`SYM_SKP);
    dset(1);
    oset(`SYM_IDL);
    run(32'h00002003, 0);
    chk_en <= 0;
    apb(1, `OFS_EXT_CTL, 32'h01000005);
    apb(1, `OFS_START, 1);
    repeat (40) @(posedge pclk);
    err(8'h5A);
    wdone();
    rd(`OFS_STATUS, 32'hFF0C, 32'h5A0C);
    apb(1, `OFS_START, 0);
    apb(1, `OFS_EXT_CTL, 32'h03000005);
    apb(1, `OFS_START, 1);
    repeat (40) @(posedge pclk);
    err(8'hA1);
    err(8'h3C);
    hold <= 1;
    repeat (60) @(posedge pclk);
    rd(`OFS_STATUS, 32'hFF0D, 32'h3C09);
    hold <= 0;
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    cmp("test_running", 0, 32'(test_running));
    rd(`OFS_EXT_CTL, '1, `CTL_RESET);
    conclude();
  end
endmodule
`default_nettype wire
